// file: periph_irq_pkg.sv
package periph_irq_pkg;

  // register byte offsets on the APB
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_FLAGS_TWO = 8'h00;
  localparam logic [7:0] OFS_FLAGS_THREE = 8'h04;
  localparam logic [7:0] OFS_ENABLES_ONE = 8'h08;
  localparam logic [7:0] OFS_ENABLES_TWO = 8'h0c;
  localparam logic [7:0] OFS_ENABLES_THREE = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;

  // register select codes
  localparam logic [2:0] SEL_FLAGS_TWO = 3'h0;
  localparam logic [2:0] SEL_FLAGS_THREE = 3'h1;
  localparam logic [2:0] SEL_ENABLES_ONE = 3'h2;
  localparam logic [2:0] SEL_ENABLES_TWO = 3'h3;
  localparam logic [2:0] SEL_ENABLES_THREE = 3'h4;
  localparam logic [2:0] SEL_CONTROL = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // values after reset
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // flag register two
  localparam int BIT_OSC_FAIL = 7;
  localparam int BIT_CMP2 = 6;
  localparam int BIT_CMP1 = 5;
  localparam int BIT_USB = 4;
  localparam int BIT_COLL1 = 3;
  localparam int BIT_LOW_V = 2;
  localparam int BIT_TMR3 = 1;
  localparam int BIT_CCP2 = 0;

  // flag register three
  localparam int BIT_SER2 = 7;
  localparam int BIT_COLL2 = 6;
  localparam int BIT_RX2 = 5;
  localparam int BIT_TX2 = 4;
  localparam int BIT_TMR4 = 3;
  localparam int BIT_CCP5 = 2;
  localparam int BIT_CCP4 = 1;
  localparam int BIT_CCP3 = 0;
  localparam logic [7:0] LEVEL_MASK_THREE = 8'h30;

  // control register
  localparam int CTRL_BIT_GATE = 0;
  localparam int CTRL_BIT_PRIO = 1;

  typedef enum logic [1:0] {
    CCP_CAPTURE = 2'h0,
    CCP_COMPARE = 2'h1,
    CCP_PWM = 2'h3
  } ccp_mode_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h0,
    APB_RESP = 2'h1
  } apb_state_type;

endpackage

// file: flag_bank_if.sv
`timescale 1ns/1ns
interface flag_bank_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] set;
  logic [WIDTH-1:0] wdata;
  logic wr;
  logic [WIDTH-1:0] flags;
  modport bank(input set, input wdata, input wr, output flags);
  modport user(output set, output wdata, output wr, input flags);
endinterface

// file: flag_bank.sv
`timescale 1ns/1ns
module flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] LEVEL_MASK = '0
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flag access
  flag_bank_if.bank fb
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // set beats a software clear in the same cycle
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (LEVEL_MASK[i])
        flags_d[i] = fb.set[i];
      else
        flags_d[i] = (flags_q[i] & ~(fb.wr & ~fb.wdata[i])) | fb.set[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= periph_irq_pkg::RST_FLAGS[WIDTH-1:0];
    else
      flags_q <= flags_d;
  end

  assign fb.flags = flags_q;

endmodule

// file: peripheral_irq_flag_enable.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - oscillator failure sets flag two bit 7; it stays until software clears it.
// - any comparator 2 or 1 input change sets flag two bit 6 or bit 5 respectively.
// - a USB interrupt request sets flag two bit 4 until cleared.
// - bus collision sets flag two bit 3 (serial 1) or flag three bit 6 (serial 2).
// - low core supply sets flag two bit 2; it stays set after the supply recovers, until software clears it.
// - timer 3 overflow sets flag two bit 1; software clears it.
// - in capture mode a timer capture sets that unit's capture/compare flag.
// - in compare mode a timer match sets that unit's flag, held until cleared.
// - in PWM mode no event of a unit sets its flag.
// - serial module 2 completing a transfer sets flag three bit 7.
// - flag three bit 5 is read-only, high while the UART 2 receive buffer is full.
// - flag three bit 4 is high while the UART 2 transmit buffer is empty.
// - timer 4 matching its period sets flag three bit 3.
// - with priority disabled, nothing passes unless the peripheral gate bit is set.
// - enable one bits 7..0 gate the eight sources of flag register one.
// - all flags and enables are zero after reset.
// - flags set regardless of any enable bit, so software may poll them.
module peripheral_irq_flag_enable #(
  parameter int NUM_CCP = 4
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [periph_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events for flag register two
  input wire logic osc_fail_evt,
  input wire logic comparator2_out,
  input wire logic comparator1_out,
  input wire logic usb_req,
  input wire logic collision1_evt,
  input wire logic core_low,
  input wire logic timer3_ovf,
  // events for flag register three
  input wire logic serial2_done,
  input wire logic collision2_evt,
  input wire logic uart2_rx_full,
  input wire logic uart2_tx_empty,
  input wire logic timer4_match,
  // capture/compare units 2,3,4,5 in index order 0..3
  input wire logic [NUM_CCP-1:0] ccp_capture,
  input wire logic [NUM_CCP-1:0] ccp_match,
  input wire logic [2*NUM_CCP-1:0] ccp_mode,
  // flag register one, kept elsewhere
  input wire logic [7:0] flags_one,
  // interrupt
  output logic irq
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic [2:0] reg_sel(input logic [periph_irq_pkg::ADDR_W-1:0] addr);
    case (addr)
      periph_irq_pkg::OFS_FLAGS_TWO: reg_sel = periph_irq_pkg::SEL_FLAGS_TWO;
      periph_irq_pkg::OFS_FLAGS_THREE: reg_sel = periph_irq_pkg::SEL_FLAGS_THREE;
      periph_irq_pkg::OFS_ENABLES_ONE: reg_sel = periph_irq_pkg::SEL_ENABLES_ONE;
      periph_irq_pkg::OFS_ENABLES_TWO: reg_sel = periph_irq_pkg::SEL_ENABLES_TWO;
      periph_irq_pkg::OFS_ENABLES_THREE: reg_sel = periph_irq_pkg::SEL_ENABLES_THREE;
      periph_irq_pkg::OFS_CONTROL: reg_sel = periph_irq_pkg::SEL_CONTROL;
      default: reg_sel = periph_irq_pkg::SEL_NONE;
    endcase
  endfunction

  // pwm mode never raises a flag
  function automatic logic ccp_event(input logic [1:0] mode, input logic cap, input logic match);
    case (mode)
      periph_irq_pkg::CCP_CAPTURE: ccp_event = cap;
      periph_irq_pkg::CCP_COMPARE: ccp_event = match;
      default: ccp_event = 1'b0;
    endcase
  endfunction

  periph_irq_pkg::apb_state_type state_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic [7:0] en_one_q;
  logic [7:0] en_two_q;
  logic [7:0] en_three_q;
  logic [1:0] ctrl_q;
  logic [1:0] cmp_prev_q;
  logic cmp_armed_q;
  logic [2:0] sel;
  logic access;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic [1:0] cmp_chg;
  logic [NUM_CCP-1:0] ccp_set;
  logic pending;

  flag_bank_if #(.WIDTH(8)) fb_two ();
  flag_bank_if #(.WIDTH(8)) fb_three ();

  assign sel = reg_sel(paddr);
  assign access = psel & penable;
  assign wr_fire = (state_q == periph_irq_pkg::APB_RESP) & access & pwrite;

  // one wait state: every transfer answers on its second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= periph_irq_pkg::APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= periph_irq_pkg::RST_RDATA;
    end
    else
    begin
      case (state_q)
        periph_irq_pkg::APB_IDLE:
        begin
          if (access)
          begin
            state_q <= periph_irq_pkg::APB_RESP;
            pready_q <= 1'b1;
            pslverr_q <= (sel == periph_irq_pkg::SEL_NONE);
            prdata_q <= pwrite ? periph_irq_pkg::RST_RDATA : {24'h00_0000, rd_byte};
          end
        end
        periph_irq_pkg::APB_RESP:
        begin
          state_q <= periph_irq_pkg::APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default:
        begin
          state_q <= periph_irq_pkg::APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // narrow registers read zero above bit 7
  always_comb
  begin
    case (sel)
      periph_irq_pkg::SEL_FLAGS_TWO: rd_byte = fb_two.flags;
      periph_irq_pkg::SEL_FLAGS_THREE: rd_byte = fb_three.flags;
      periph_irq_pkg::SEL_ENABLES_ONE: rd_byte = en_one_q;
      periph_irq_pkg::SEL_ENABLES_TWO: rd_byte = en_two_q;
      periph_irq_pkg::SEL_ENABLES_THREE: rd_byte = en_three_q;
      periph_irq_pkg::SEL_CONTROL: rd_byte = {6'h00, ctrl_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // first cycle after reset only arms the detector, so no false change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_prev_q <= 2'h0;
      cmp_armed_q <= 1'b0;
    end
    else
    begin
      cmp_prev_q <= {comparator2_out, comparator1_out};
      cmp_armed_q <= 1'b1;
    end
  end

  assign cmp_chg = cmp_armed_q ? (cmp_prev_q ^ {comparator2_out, comparator1_out}) : 2'h0;

  always_comb
  begin
    for (int i = 0; i < NUM_CCP; i++)
      ccp_set[i] = ccp_event(ccp_mode[2*i +: 2], ccp_capture[i], ccp_match[i]);
  end

  // sources feed the flags with no enable in the path
  assign fb_two.set = {osc_fail_evt, cmp_chg, usb_req, collision1_evt,
                       core_low, timer3_ovf, ccp_set[0]};
  assign fb_two.wr = wr_fire & (sel == periph_irq_pkg::SEL_FLAGS_TWO);
  assign fb_two.wdata = pwdata[7:0];

  // bits 5 and 4 mirror the uart 2 buffer state, writes leave them alone
  assign fb_three.set = {serial2_done, collision2_evt, uart2_rx_full, uart2_tx_empty,
                         timer4_match, ccp_set[3], ccp_set[2], ccp_set[1]};
  assign fb_three.wr = wr_fire & (sel == periph_irq_pkg::SEL_FLAGS_THREE);
  assign fb_three.wdata = pwdata[7:0];

  flag_bank #(.WIDTH(8), .LEVEL_MASK(8'h00)) u_flags_two (
    .pclk(pclk),
    .presetn(presetn),
    .fb(fb_two.bank)
  );

  flag_bank #(.WIDTH(8), .LEVEL_MASK(periph_irq_pkg::LEVEL_MASK_THREE)) u_flags_three (
    .pclk(pclk),
    .presetn(presetn),
    .fb(fb_three.bank)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_one_q <= periph_irq_pkg::RST_ENABLES;
    else if (wr_fire && sel == periph_irq_pkg::SEL_ENABLES_ONE)
      en_one_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_two_q <= periph_irq_pkg::RST_ENABLES;
    else if (wr_fire && sel == periph_irq_pkg::SEL_ENABLES_TWO)
      en_two_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_three_q <= periph_irq_pkg::RST_ENABLES;
    else if (wr_fire && sel == periph_irq_pkg::SEL_ENABLES_THREE)
      en_three_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= periph_irq_pkg::RST_CONTROL;
    else if (wr_fire && sel == periph_irq_pkg::SEL_CONTROL)
      ctrl_q <= pwdata[1:0];
  end

  assign pending = |(flags_one & en_one_q) | |(fb_two.flags & en_two_q)
                 | |(fb_three.flags & en_three_q);

  // with priorities on, the gate bit only governs the low level, outside this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= pending & (ctrl_q[periph_irq_pkg::CTRL_BIT_PRIO] | ctrl_q[periph_irq_pkg::CTRL_BIT_GATE]);
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  AST_OSC_FAIL_STICKY: assert property (
    osc_fail_evt |=> fb_two.flags[periph_irq_pkg::BIT_OSC_FAIL]
      ##1 (fb_two.flags[periph_irq_pkg::BIT_OSC_FAIL] || $past(fb_two.wr)))
    else $error("oscillator fail flag not held");

  AST_CMP_CHANGE: assert property (
    cmp_armed_q && (comparator2_out != cmp_prev_q[1]) |=> fb_two.flags[periph_irq_pkg::BIT_CMP2])
    else $error("comparator 2 change missed");

  AST_USB_SET: assert property (
    usb_req |=> fb_two.flags[periph_irq_pkg::BIT_USB])
    else $error("usb flag not set");

  AST_COLLISION: assert property (
    collision1_evt || collision2_evt |=> (fb_two.flags[periph_irq_pkg::BIT_COLL1] || !$past(collision1_evt))
      && (fb_three.flags[periph_irq_pkg::BIT_COLL2] || !$past(collision2_evt)))
    else $error("collision flag not set");

  AST_LOW_V_RISE: assert property (
    $rose(fb_two.flags[periph_irq_pkg::BIT_LOW_V]) |-> $past(core_low))
    else $error("low voltage flag set without cause");

  AST_TMR3_SET_WINS: assert property (
    timer3_ovf && fb_two.wr && !fb_two.wdata[periph_irq_pkg::BIT_TMR3]
      |=> fb_two.flags[periph_irq_pkg::BIT_TMR3])
    else $error("timer 3 overflow lost to clear");

  AST_CCP_CAPTURE: assert property (
    ccp_mode[1:0] == periph_irq_pkg::CCP_CAPTURE && ccp_capture[0]
      |=> fb_two.flags[periph_irq_pkg::BIT_CCP2])
    else $error("capture did not set flag");

  AST_CCP_PWM_QUIET: assert property (
    $rose(fb_three.flags[periph_irq_pkg::BIT_CCP5]) |-> $past(ccp_mode[7:6]) != periph_irq_pkg::CCP_PWM)
    else $error("flag set in pwm mode");

  AST_RX_MIRROR: assert property (
    fb_three.flags[periph_irq_pkg::BIT_RX2] == $past(uart2_rx_full))
    else $error("receive flag not mirroring buffer");

  AST_GATE_BLOCKS: assert property (
    irq_q && !$past(ctrl_q[periph_irq_pkg::CTRL_BIT_PRIO]) |-> $past(ctrl_q[periph_irq_pkg::CTRL_BIT_GATE]))
    else $error("interrupt passed with gate closed");

  AST_IRQ_RAISE: assert property (
    (fb_two.flags & en_two_q) != 8'h00 && ctrl_q[periph_irq_pkg::CTRL_BIT_GATE] |=> irq_q)
    else $error("enabled flag did not raise irq");

  AST_APB_ANSWER: assert property (
    $rose(access) && state_q == periph_irq_pkg::APB_IDLE |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  AST_CMP1_CHANGE: assert property (
    cmp_armed_q && (comparator1_out != cmp_prev_q[0]) |=> fb_two.flags[periph_irq_pkg::BIT_CMP1])
    else $error("comparator 1 change missed");

  AST_CCP_COMPARE: assert property (
    ccp_mode[1:0] == periph_irq_pkg::CCP_COMPARE && ccp_match[0]
      |=> fb_two.flags[periph_irq_pkg::BIT_CCP2])
    else $error("compare match did not set flag");

  AST_SER2_SET: assert property (
    serial2_done |=> fb_three.flags[periph_irq_pkg::BIT_SER2])
    else $error("serial 2 flag not set");

  AST_TX_MIRROR: assert property (
    fb_three.flags[periph_irq_pkg::BIT_TX2] == $past(uart2_tx_empty))
    else $error("transmit flag not mirroring buffer");

  AST_TMR4_SET: assert property (
    timer4_match |=> fb_three.flags[periph_irq_pkg::BIT_TMR4])
    else $error("timer 4 flag not set");

  AST_USB_CLEAR: assert property (
    fb_two.wr && !fb_two.wdata[periph_irq_pkg::BIT_USB] && !usb_req
      |=> !fb_two.flags[periph_irq_pkg::BIT_USB])
    else $error("usb flag survived a clear");

  // a quiet source set must never leave irq high, whatever the gate bits say
  AST_IRQ_QUIET: assert property (
    (flags_one & en_one_q) == 8'h00 && (fb_two.flags & en_two_q) == 8'h00
      && (fb_three.flags & en_three_q) == 8'h00 |=> !irq_q)
    else $error("irq without an enabled flag");

  AST_UNMAPPED_ERR: assert property (
    state_q == periph_irq_pkg::APB_IDLE && access && sel == periph_irq_pkg::SEL_NONE
      |=> pslverr_q && pready_q)
    else $error("unmapped access not refused");

endmodule

// file: peripheral_events.sv
`timescale 1ns/1ns
module peripheral_events (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from bench
  input wire logic fire,
  input wire logic [4:0] fire_sel,
  // event lines
  output logic [17:0] evt_q,
  output logic [1:0] cmp_q
);
  // single-cycle pulses, idle low between events so no stale level re-sets a flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_q <= 18'h0;
    else
      evt_q <= fire ? (18'h1 << fire_sel) : 18'h0;
  end
  // comparator outputs are levels: codes 1 and 2 flip them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_q <= 2'h0;
    else if (fire && (fire_sel == 5'h1 || fire_sel == 5'h2))
      cmp_q[fire_sel == 5'h1] <= ~cmp_q[fire_sel == 5'h1];
  end
endmodule

// file: peripheral_irq_flag_enable_tb_top.sv
`timescale 1ns/1ns
module peripheral_irq_flag_enable_tb_top;
  typedef struct packed {logic [31:0] d; logic e;} exp_type;
  localparam logic [7:0] F2 = periph_irq_pkg::OFS_FLAGS_TWO;
  localparam logic [7:0] F3 = periph_irq_pkg::OFS_FLAGS_THREE;
  localparam logic [7:0] E1 = periph_irq_pkg::OFS_ENABLES_ONE;
  localparam logic [7:0] CT = periph_irq_pkg::OFS_CONTROL;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, fire = 0, rx_full = 0, tx_empty = 0;
  logic [4:0] fire_sel = 5'h0;
  logic [17:0] evt;
  logic [1:0] cmp;
  logic [7:0] ccp_mode = 8'h0, flags_one = 8'h0;
  exp_type expq[$];
  exp_type e;
  int mismatches = 0, cmp_count = 0;

  always #5 pclk = ~pclk;

  peripheral_events model_u (.pclk(pclk), .presetn(presetn), .fire(fire), .fire_sel(fire_sel),
    .evt_q(evt), .cmp_q(cmp));

  peripheral_irq_flag_enable #(.NUM_CCP(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_fail_evt(evt[0]), .comparator2_out(cmp[1]), .comparator1_out(cmp[0]), .usb_req(evt[3]),
    .collision1_evt(evt[4]), .core_low(evt[5]), .timer3_ovf(evt[6]), .serial2_done(evt[7]),
    .collision2_evt(evt[8]), .uart2_rx_full(rx_full), .uart2_tx_empty(tx_empty),
    .timer4_match(evt[9]), .ccp_capture(evt[13:10]), .ccp_match(evt[17:14]),
    .ccp_mode(ccp_mode), .flags_one(flags_one), .irq(irq));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp);
    int n;
    n = 0;
    expq.push_back({wr ? 32'h0 : exp, a > CT});
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (n >= 20)
    begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0, {24'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask

  task automatic pulse(input int c);
    fire <= 1;
    fire_sel <= 5'(c);
    @(posedge pclk);
    fire <= 0;
    tick(2);
  endtask

  task automatic irq_is(input logic v);
    tick(2);
    check("irq", {31'h0, irq}, {31'h0, v});
  endtask

  // where event code c lands: offset in high byte, bit mask in low byte
  function automatic logic [15:0] spot(input int c);
    if (c < 7)
      return {F2, 8'h80 >> c};
    if (c < 9)
      return {F3, 8'h80 >> (c - 7)};
    if (c == 9)
      return {F3, 8'h08};
    if (c == 10)
      return {F2, 8'h01};
    return {F3, 8'h01 << (c - 11)};
  endfunction

  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      if (expq.size() == 0)
        check("queue", 32'h1, 32'h0);
      else
      begin
        e = expq.pop_front();
        check("prdata", prdata, e.d);
        check("pslverr", {31'h0, pslverr}, {31'h0, e.e});
      end
    end
  end

  initial
  begin
    logic [15:0] s;
    logic [31:0] r;
    logic [1:0] mv;
    void'($urandom(24));
    tick(5);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a <= 8'h14; a += 4)
      rd(8'(a), 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h18, 32'hff);
    wr(F2, 32'hff);
    rd(F2, 8'h00);
    for (int c = 0; c < 10; c++)
    begin
      s = spot(c);
      pulse(c);
      tick(3);
      rd(s[15:8], s[7:0]);
      wr(s[15:8], 32'h0);
      rd(s[15:8], 8'h00);
    end
    for (int u = 0; u < 4; u++)
    begin
      for (int m = 0; m < 3; m++)
      begin
        s = spot(10 + u);
        mv = (m == 2) ? 2'h3 : 2'(m);
        ccp_mode <= {4{mv}};
        @(posedge pclk);
        pulse(m == 1 ? 14 + u : 10 + u);
        if (m == 2)
          pulse(14 + u);
        rd(s[15:8], m == 2 ? 8'h00 : s[7:0]);
        wr(s[15:8], 32'h0);
      end
    end
    tx_empty <= 1;
    tick(2);
    rd(F3, 8'h10);
    wr(F3, 32'h0);
    rd(F3, 8'h10);
    tx_empty <= 0;
    rx_full <= 1;
    tick(2);
    rd(F3, 8'h20);
    wr(F3, 32'h0);
    rd(F3, 8'h20);
    rx_full <= 0;
    tick(2);
    rd(F3, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      wr(E1, r);
      rd(E1, r[7:0]);
      flags_one <= 8'h01 << i;
      wr(E1, {24'h0, ~(8'h01 << i)});
      wr(CT, 32'h1);
      irq_is(1'b0);
      wr(E1, {24'h0, 8'h01 << i});
      wr(CT, 32'h0);
      irq_is(1'b0);
      wr(CT, 32'h1);
      irq_is(1'b1);
      wr(CT, 32'h2);
      irq_is(1'b1);
      wr(CT, 32'h0);
      flags_one <= 8'h00;
    end
    wr(E1, 32'h0);
    wr(periph_irq_pkg::OFS_ENABLES_TWO, 32'h02);
    wr(CT, 32'h1);
    // overflow reaches the flag on the edge that commits the clear: the set must win
    fork
      wr(F2, 32'h0);
      begin
        tick(1);
        fire <= 1;
        fire_sel <= 5'h6;
        @(posedge pclk);
        fire <= 0;
      end
    join
    irq_is(1'b1);
    rd(F2, 8'h02);
    wr(F2, 32'h0);
    irq_is(1'b0);
    // mid-run reset with a flag, enables and gate all set
    pulse(6);
    wr(E1, 32'hff);
    presetn <= 0;
    tick(2);
    presetn <= 1;
    @(posedge pclk);
    check("irq after reset", {31'h0, irq}, 32'h0);
    for (int a = 0; a <= 8'h14; a += 4)
      rd(8'(a), 8'h00);
    check("queue left", expq.size(), 32'h0);
    conclude();
  end
endmodule
